// ==== logic/ces_fifo.sv ====
`timescale 1ns/100ps
module ces_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : ces_fifo

// ==== logic/ces_pkg.sv ====
package ces_pkg;

  // register window, byte offsets inside the 64 KiB memory region
  localparam logic [15:0] OFS_CONTROL    = 16'h0070;
  localparam logic [15:0] OFS_SHIFT_DATA = 16'h0074;
  localparam int          WIN_AW         = 16;

  // control register fields
  localparam int CTL_CS_BIT   = 0;
  localparam int CTL_BUSY_BIT = 1;
  localparam int CTL_DONE_BIT = 2;

  // reset values
  localparam logic       RST_CS_N    = 1'b1;
  localparam logic [7:0] RST_RX_BYTE = 8'h00;

  // configuration header dword indices
  localparam logic [5:0] CFG_IDX_ID     = 6'h00;
  localparam logic [5:0] CFG_IDX_SUB_ID = 6'h0b;

  // serial timing
  localparam int          CLK_MHZ      = 25;
  localparam int          SCLK_DIV     = 3;
  localparam logic [1:0]  DIV_LAST     = 2'(SCLK_DIV - 1);
  localparam logic [1:0]  DIV_RISE     = 2'(SCLK_DIV - 2);
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam int          SAMPLE_LAT   = 5;

  // fallback indicator blink half period
  localparam int BLINK_HALF_MS  = 250;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;

  // outgoing byte buffer
  localparam int TXQ_WIDTH = 8;
  localparam int TXQ_DEPTH = 8;

  typedef enum logic [1:0] {
    CES_IDLE  = 2'b00,
    CES_SHIFT = 2'b01,
    CES_DRAIN = 2'b11
  } ces_state_e;

  // one decoded target access of the memory window
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [WIN_AW-1:0] addr;
    logic [3:0]        be;
    logic [31:0]       wdata;
  } ces_win_req_s;

endpackage : ces_pkg

// ==== logic/ces_spi_port.sv ====
// Summary of operation
// - Byte data register at 0x74; reading returns the last received byte.
// - Control register at 0x70: chip select, busy, byte-done; upper bits zero.
// - A data write clears byte-done and shifts out while shifting in; here a byte completing in the same cycle with the queue empty sets it instead.
// - Serial clock runs at the bus clock divided by three.
// - Byte-done sets once all eight bits have completed; here only when no further byte is queued.
// - After byte-done the received byte is readable; next byte may follow.
// - Target-only window: one 64 KiB, 32-bit, non-cacheable region.
// - Configuration header presents vendor, device and subsystem codes.
// - A failed primary image is replaced by the fallback image.
// - Running from fallback blinks the red status indicator.
// - User indicators are lit by a low output.
// - Timing-critical logic should use the precise on-card oscillator.
`timescale 1ns/100ps
module ces_spi_port #(
  parameter int        BLINK_HALF_CYC = ces_pkg::BLINK_HALF_CYC,
  parameter bit [15:0] VENDOR_CODE    = 16'h1234,  // arbitrary value
  parameter bit [15:0] DEVICE_CODE    = 16'h0001,  // arbitrary value
  parameter bit [15:0] SUB_VENDOR     = 16'h1234,  // arbitrary value
  parameter bit [15:0] SUB_DEVICE     = 16'h0001   // arbitrary value
) (
  input  wire logic                 mclk_in,
  input  wire logic                 rst_in,
  input  wire ces_pkg::ces_win_req_s win_req_in,
  output logic                      win_ready_out,
  output logic                      win_rvalid_out,
  output logic [31:0]               win_rdata_out,
  input  wire logic                 cfg_rd_in,
  input  wire logic [5:0]           cfg_idx_in,
  output logic [31:0]               cfg_rdata_out,
  output logic                      spi_sclk_out,
  output logic                      spi_mosi_out,
  output logic                      spi_cs_n_out,
  input  wire logic                 spi_miso_in,
  input  wire logic                 fallback_loaded_in,
  output logic                      init_led_n_out,
  output logic [1:0]                user_led_n_out
);
  localparam int BW = $clog2(BLINK_HALF_CYC + 1);
  localparam int SAMPLE_PIPE_W = ces_pkg::SAMPLE_LAT;

  ces_pkg::ces_state_e  state;
  ces_pkg::ces_state_e  next_state;
  logic [1:0]           div;
  logic [2:0]           bit_cnt;
  logic [3:0]           rx_cnt;
  logic [7:0]           tx_shift;
  logic [7:0]           rx_shift;
  logic [7:0]           rx_byte;
  logic                 done_flag;
  logic [SAMPLE_PIPE_W-1:0] samp_pipe;
  logic [2:0]           miso_sync;
  logic                 miso_f;
  logic [2:0]           fb_sync;
  logic                 fb_f;
  logic [BW-1:0]        blink_cnt;
  logic                 blink_on;
  logic [3:0]           pulse_cnt;

  // window decode; only dword offsets inside the 64 KiB region matter
  wire hit_ctl  = (win_req_in.addr[15:2] == ces_pkg::OFS_CONTROL[15:2]);
  wire hit_data = (win_req_in.addr[15:2] == ces_pkg::OFS_SHIFT_DATA[15:2]);
  wire wr_ctl   = win_req_in.wr && win_req_in.be[0] && hit_ctl;
  wire wr_data  = win_req_in.wr && win_req_in.be[0] && hit_data && win_ready_out;
  wire txq_valid;
  wire [7:0] txq_data;
  wire txq_ready;
  wire txq_pop    = (state == ces_pkg::CES_IDLE) && txq_valid;
  wire bit_end    = (state == ces_pkg::CES_SHIFT) && (div == ces_pkg::DIV_LAST);
  wire sample_now = samp_pipe[SAMPLE_PIPE_W-1];
  wire byte_in    = sample_now && (rx_cnt == ces_pkg::BITS_PER_BYTE - 4'h1);
  wire busy       = (state != ces_pkg::CES_IDLE) || txq_valid;
  wire [31:0] ctl_word  = {29'h0, done_flag, busy, spi_cs_n_out};
  wire [31:0] data_word = {24'h0, rx_byte};
  wire [31:0] rd_mux = hit_ctl ? ctl_word : (hit_data ? data_word : 32'h0);
  wire [31:0] cfg_mux =
      (cfg_idx_in == ces_pkg::CFG_IDX_ID)     ? {DEVICE_CODE, VENDOR_CODE} :
      (cfg_idx_in == ces_pkg::CFG_IDX_SUB_ID) ? {SUB_DEVICE, SUB_VENDOR}   :
      32'h0;

  // outgoing bytes queue here so back-to-back writes are not lost
  ces_fifo #(
    .WIDTH (ces_pkg::TXQ_WIDTH),
    .DEPTH (ces_pkg::TXQ_DEPTH)
  ) u_txq (
    .clk_in        (mclk_in),
    .rst_in        (rst_in),
    .in_valid_in   (wr_data),
    .in_ready_out  (txq_ready),
    .in_data_in    (win_req_in.wdata[7:0]),
    .out_valid_out (txq_valid),
    .out_ready_in  (txq_pop),
    .out_data_out  (txq_data)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      ces_pkg::CES_IDLE: begin
        if (txq_valid) begin
          next_state = ces_pkg::CES_SHIFT;
        end
      end
      ces_pkg::CES_SHIFT: begin
        if (bit_end && bit_cnt == ces_pkg::BIT_LAST) begin
          next_state = ces_pkg::CES_DRAIN;
        end
      end
      ces_pkg::CES_DRAIN: begin
        if (byte_in) begin
          next_state = ces_pkg::CES_IDLE;
        end
      end
      default: next_state = ces_pkg::CES_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ces_pkg::CES_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // bit timing: low, low, high per bit
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      div     <= 2'h0;
      bit_cnt <= 3'h0;
    end else if (state != ces_pkg::CES_SHIFT) begin
      div     <= 2'h0;
      bit_cnt <= 3'h0;
    end else begin
      div     <= (div == ces_pkg::DIV_LAST) ? 2'h0 : div + 2'h1;
      bit_cnt <= bit_end ? bit_cnt + 3'h1 : bit_cnt;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      spi_sclk_out <= 1'b0;
      spi_mosi_out <= 1'b0;
      tx_shift     <= 8'h00;
    end else begin
      spi_sclk_out <= (state == ces_pkg::CES_SHIFT) && (div == ces_pkg::DIV_RISE);
      if (txq_pop) begin
        tx_shift     <= {txq_data[6:0], 1'b0};
        spi_mosi_out <= txq_data[7];
      end else if (bit_end && bit_cnt != ces_pkg::BIT_LAST) begin
        tx_shift     <= {tx_shift[6:0], 1'b0};
        spi_mosi_out <= tx_shift[7];
      end
    end
  end

  // sample strobe delayed to match the input synchroniser and filter
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      samp_pipe <= '0;
      miso_sync <= 3'h0;
      miso_f    <= 1'b0;
    end else begin
      samp_pipe <= {samp_pipe[SAMPLE_PIPE_W-2:0],
                    (state == ces_pkg::CES_SHIFT) && (div == ces_pkg::DIV_RISE)};
      miso_sync <= {miso_sync[1:0], spi_miso_in};
      if (miso_sync[1] == miso_sync[2]) begin
        miso_f <= miso_sync[2];
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_shift <= 8'h00;
      rx_cnt   <= 4'h0;
      rx_byte  <= ces_pkg::RST_RX_BYTE;
    end else begin
      if (txq_pop) begin
        rx_cnt <= 4'h0;
      end else if (sample_now) begin
        rx_shift <= {rx_shift[6:0], miso_f};
        rx_cnt   <= rx_cnt + 4'h1;
      end
      if (byte_in) begin
        rx_byte <= {rx_shift[6:0], miso_f};
      end
    end
  end

  // completion with the queue empty wins over a clearing write in the same cycle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      done_flag <= 1'b0;
    end else if (byte_in && !txq_valid) begin
      done_flag <= 1'b1;
    end else if (wr_data) begin
      done_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      spi_cs_n_out <= ces_pkg::RST_CS_N;
    end else if (wr_ctl) begin
      spi_cs_n_out <= win_req_in.wdata[ces_pkg::CTL_CS_BIT];
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      win_ready_out  <= 1'b1;
      win_rvalid_out <= 1'b0;
      win_rdata_out  <= 32'h0;
      cfg_rdata_out  <= 32'h0;
    end else begin
      // stays low one cycle beyond the queue filling, so no write is dropped
      win_ready_out  <= txq_ready && !(wr_data && !txq_pop);
      win_rvalid_out <= win_req_in.rd;
      win_rdata_out  <= win_req_in.rd ? rd_mux : 32'h0;
      cfg_rdata_out  <= cfg_rd_in ? cfg_mux : 32'h0;
    end
  end

  // fallback image indication from the configuration logic
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fb_sync <= 3'h0;
      fb_f    <= 1'b0;
    end else begin
      fb_sync <= {fb_sync[1:0], fallback_loaded_in};
      if (fb_sync[1] == fb_sync[2]) begin
        fb_f <= fb_sync[2];
      end
    end
  end

  // indicator timing only; nothing here needs the precise oscillator
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      blink_cnt <= '0;
      blink_on  <= 1'b0;
    end else if (!fb_f) begin
      blink_cnt <= '0;
      blink_on  <= 1'b0;
    end else if (blink_cnt == BW'(BLINK_HALF_CYC - 1)) begin
      blink_cnt <= '0;
      blink_on  <= !blink_on;
    end else begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      init_led_n_out <= 1'b1;
      user_led_n_out <= 2'h3;
    end else begin
      init_led_n_out <= !blink_on;
      user_led_n_out <= {spi_cs_n_out, !busy};
    end
  end

  // serial clock high cycles since the byte was taken, for the checks below
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pulse_cnt <= 4'h0;
    end else if (txq_pop) begin
      pulse_cnt <= 4'h0;
    end else if (spi_sclk_out) begin
      pulse_cnt <= pulse_cnt + 4'h1;
    end
  end

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_start;
    txq_pop;
  endsequence

  sequence s_one_bit;
    !spi_sclk_out ##1 !spi_sclk_out ##1 spi_sclk_out;
  endsequence

  AST_WRITE_CLEARS_DONE: assert property (
    (wr_data && !byte_in) |=> !done_flag
  ) else $error("byte-done not cleared by data write");

  AST_SCLK_PERIOD: assert property (
    s_start |=> s_one_bit ##1 s_one_bit ##1 s_one_bit
  ) else $error("serial clock not at one third of bus clock");

  AST_EIGHT_PULSES: assert property (
    s_start |-> ##25 (state == ces_pkg::CES_DRAIN)
  ) else $error("shift phase not 24 cycles long");

  AST_DONE_SETS: assert property (
    (byte_in && !txq_valid) |=> done_flag ##1 $stable(rx_byte)
  ) else $error("byte-done not set after last bit");

  AST_RX_CAPTURE: assert property (
    byte_in |=> rx_byte == $past(({rx_shift[6:0], miso_f}))
  ) else $error("received byte not captured");

  AST_BUSY_HELD: assert property (
    wr_data |=> busy
  ) else $error("busy low after data write");

  AST_BUSY_ENDS: assert property (
    (byte_in && !txq_valid && !wr_data) |=> !busy
  ) else $error("busy held after final bit");

  AST_SCLK_IDLE: assert property (
    (state == ces_pkg::CES_IDLE) |-> ##1 !spi_sclk_out
  ) else $error("serial clock not idle low");

  AST_MOSI_STABLE_HIGH: assert property (
    spi_sclk_out |-> $stable(spi_mosi_out)
  ) else $error("data changed while clock high");

  AST_CS_FOLLOWS: assert property (
    wr_ctl |=> spi_cs_n_out == $past(win_req_in.wdata[0])
  ) else $error("chip select not written");

  AST_EIGHT_RISES: assert property (
    byte_in |-> (pulse_cnt == ces_pkg::BITS_PER_BYTE)
  ) else $error("byte finished without eight clock pulses");

  AST_SAMPLE_LAG: assert property (
    $rose(spi_sclk_out) |-> ##4 sample_now
  ) else $error("input not sampled after rising clock");

  AST_READY_SAFE: assert property (
    !txq_ready |-> !win_ready_out
  ) else $error("write accepted while queue full");

  AST_CTL_UPPER_ZERO: assert property (
    (win_req_in.rd && hit_ctl) |=> win_rvalid_out && (win_rdata_out[31:3] == 29'h0)
  ) else $error("control read shows unused bits");

  AST_BUSY_LED: assert property (
    busy |=> !user_led_n_out[0]
  ) else $error("busy indicator not lit");

  AST_INIT_DARK: assert property (
    !fb_f |-> ##2 init_led_n_out
  ) else $error("status indicator lit without fallback");

endmodule : ces_spi_port

// ==== sim/ces_eeprom_model.sv ====
`timescale 1ns/100ps
module ces_eeprom_model #(
  parameter logic [7:0] FIRST_RESP = 8'h3c
) (
  input  wire logic       sclk_in,
  input  wire logic       mosi_in,
  input  wire logic       cs_n_in,
  output logic            miso_out,
  output logic      [7:0] last_rx_out,
  output int              n_bytes_out
);
  logic [7:0] tx;
  logic [7:0] rx;
  int         cnt;
  // deselected: show the inverse so a stale bit never passes
  assign miso_out = cs_n_in ? ~tx[7] : tx[7];
  initial begin
    tx = FIRST_RESP;
    rx = 8'h00;
    cnt = 0;
    n_bytes_out = 0;
    last_rx_out = 8'h00;
  end
  always @(negedge cs_n_in) begin
    tx = FIRST_RESP;
    cnt = 0;
  end
  always @(posedge sclk_in) begin
    if (!cs_n_in) begin
      rx = {rx[6:0], mosi_in};
      cnt = cnt + 1;
    end
  end
  // answer of each byte after the first of a selection is the inverse of the byte before it
  always @(negedge sclk_in) begin
    if (!cs_n_in) begin
      if (cnt == 8) begin
        last_rx_out = rx;
        n_bytes_out = n_bytes_out + 1;
        tx = ~rx;
        cnt = 0;
      end else begin
        tx = {tx[6:0], 1'b0};
      end
    end
  end
endmodule : ces_eeprom_model

// ==== sim/config_eeprom_spi_port_tb.sv ====
`timescale 1ns/100ps
module config_eeprom_spi_port_tb;
  logic                 mclk, rst, cfg_rd, fb, ready, rvalid, sclk, mosi, cs_n, miso, init_led;
  ces_pkg::ces_win_req_s req;
  logic [31:0]          rdata, cfg_rdata;
  logic [5:0]           cfg_idx;
  logic [1:0]           user_led;
  logic [7:0]           last_rx;
  int                   n_rx, n_errors, total_checks;
  localparam logic [15:0] CTL = ces_pkg::OFS_CONTROL;
  localparam logic [15:0] DAT = ces_pkg::OFS_SHIFT_DATA;

  ces_spi_port #(.BLINK_HALF_CYC(4), .VENDOR_CODE(16'h1111), .DEVICE_CODE(16'h2222),
    .SUB_VENDOR(16'h3333), .SUB_DEVICE(16'h4444)) dut (  // arbitrary codes
    .mclk_in(mclk), .rst_in(rst), .win_req_in(req), .win_ready_out(ready),
    .win_rvalid_out(rvalid), .win_rdata_out(rdata), .cfg_rd_in(cfg_rd),
    .cfg_idx_in(cfg_idx), .cfg_rdata_out(cfg_rdata), .spi_sclk_out(sclk),
    .spi_mosi_out(mosi), .spi_cs_n_out(cs_n), .spi_miso_in(miso),
    .fallback_loaded_in(fb), .init_led_n_out(init_led), .user_led_n_out(user_led));
  ces_eeprom_model eeprom (.sclk_in(sclk), .mosi_in(mosi),
    .cs_n_in(cs_n), .miso_out(miso), .last_rx_out(last_rx), .n_bytes_out(n_rx));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge mclk);
    while (ready !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    check("ready in time", n < 100, 1'b1);
    req = '{wr:1'b1, rd:1'b0, addr:a, be:4'h1, wdata:{24'h0, d}};
    @(negedge mclk);
    req = '0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(negedge mclk);
    req = '{wr:1'b0, rd:1'b1, addr:a, be:4'hf, wdata:32'h0};
    @(negedge mclk);
    req = '0;
    d = 'x;
    repeat (2) begin
      if (rvalid === 1'b1) d = rdata;
      @(negedge mclk);
    end
  endtask : rd
  task automatic wait_done(output logic [31:0] c);
    int n;
    n = 0;
    c = '0;
    while (c[ces_pkg::CTL_DONE_BIT] !== 1'b1 && n < 150) begin
      rd(CTL, c);
      n++;
    end
    check("done in time", c[ces_pkg::CTL_DONE_BIT], 1'b1);
  endtask : wait_done

  task automatic t_reset();
    logic [31:0] v;
    check("sclk idle", sclk, 1'b0);
    check("cs idle", cs_n, 1'b1);
    check("user leds", user_led, 2'b11);
    rd(CTL, v);
    check("ctl reset", v & 32'hffff_fffb, 32'h1);
    rd(DAT, v);
    check("data reset", v, {24'h0, ces_pkg::RST_RX_BYTE});
    rd(16'h0078, v);
    check("unmapped", v, 32'h0);
    wr(CTL, 8'h07);
    rd(CTL, v);
    check("ro bits", v & 32'hffff_fffb, 32'h1);
  endtask : t_reset
  task automatic t_cfg();
    logic [5:0]  idx [3] = '{6'h00, 6'h0b, 6'h01};
    logic [31:0] exp [3] = '{32'h2222_1111, 32'h4444_3333, 32'h0};
    for (int i = 0; i < 3; i++) begin
      @(negedge mclk);
      cfg_rd = 1'b1;
      cfg_idx = idx[i];
      @(negedge mclk);
      cfg_rd = 1'b0;
      check("cfg word", cfg_rdata, exp[i]);
    end
  endtask : t_cfg
  task automatic t_byte();
    logic [31:0] v;
    time         t0;
    wr(CTL, 8'h00);
    check("cs asserted", cs_n, 1'b0);
    wr(DAT, 8'ha5);
    @(negedge mclk);
    check("busy and cs leds", user_led, 2'b00);
    @(posedge sclk);
    t0 = $time;
    @(posedge sclk);
    check("sclk period", 32'($time - t0), 32'd120);
    wait_done(v);
    check("done not busy", v & 32'h6, 32'h4);
    check("byte sent", last_rx, 8'ha5);
    rd(DAT, v);
    check("byte received", v, 32'h3c);
  endtask : t_byte
  task automatic t_multi(input logic [23:0] addr);
    logic [31:0] v;
    logic [7:0]  cmd [4];
    logic [7:0]  exp8;
    cmd = '{8'h03, addr[23:16], addr[15:8], addr[7:0]};
    exp8 = 8'h3c;
    wr(CTL, 8'h01);
    wr(CTL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(DAT, cmd[i]);
      rd(CTL, v);
      check("done cleared", v[ces_pkg::CTL_DONE_BIT], 1'b0);
      wait_done(v);
      check("cmd sent", last_rx, cmd[i]);
      rd(DAT, v);
      check("chained rx", v, {24'h0, exp8});
      exp8 = ~cmd[i];
    end
    wr(CTL, 8'h01);
    check("cs released", cs_n, 1'b1);
  endtask : t_multi
  task automatic t_fill();
    logic [31:0] v;
    int          n, m, base;
    wr(CTL, 8'h00);
    base = n_rx;
    n = 0;
    m = 0;
    @(negedge mclk);
    while (m < 3 && n < 12) begin
      if (ready === 1'b1) begin
        req = '{wr:1'b1, rd:1'b0, addr:DAT, be:4'h1, wdata:{24'h0, 8'h10 + 8'(n)}};
        n++;
        m = 0;
      end else begin
        req = '0;
        m++;
      end
      @(negedge mclk);
    end
    req = '0;
    check("queue refuses", n >= 8 && n <= 9, 1'b1);
    wait_done(v);
    check("bytes sent", n_rx - base, n);
    check("last byte", last_rx, 8'h10 + 8'(n - 1));
    rd(DAT, v);
    check("last rx", v, {24'h0, ~(8'h10 + 8'(n - 2))});
    wr(CTL, 8'h01);
  endtask : t_fill
  task automatic t_led();
    int   n;
    logic p;
    fb = 1'b1;
    n = 0;
    p = init_led;
    repeat (40) begin
      @(negedge mclk);
      if (init_led !== p) n++;
      p = init_led;
    end
    check("blink", n >= 4, 1'b1);
    fb = 1'b0;
    repeat (12) @(negedge mclk);
    n = 0;
    repeat (20) begin
      @(negedge mclk);
      if (init_led !== 1'b1) n++;
    end
    check("steady dark", n, 0);
  endtask : t_led

  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    #(40 * 20000);
    n_errors++;
    results();
  end
  initial begin
    rst = 1'b1;
    req = '0;
    cfg_rd = 1'b0;
    cfg_idx = 6'h00;
    fb = 1'b0;
    n_errors = 0;
    total_checks = 0;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_cfg();
    t_byte();
    t_multi(24'h080000);
    t_multi(24'h0e0000);
    t_fill();
    t_led();
    results();
  end
endmodule : config_eeprom_spi_port_tb
